// ===== verilog/fmt_pkg.sv
// Shared constants and types of the image output formatter
package fmt_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] PAT_OFS = 8'h04;
   localparam logic [7:0] BAL_OFS = 8'h08;
   localparam logic [7:0] STAT_OFS = 8'h0C;

   // Control word fields
   localparam int CTRL_ACQ = 0;
   localparam int CTRL_MX = 1;
   localparam int CTRL_MY = 2;
   localparam int CTRL_FMT_LSB = 3;
   localparam int CTRL_ADC_LSB = 6;
   localparam int CTRL_PHASE_LSB = 8;
   localparam int CTRL_GAIN_LSB = 10;

   // Pattern word fields
   localparam int PAT_SEL = 0;
   localparam int PAT_CHOICE_LSB = 1;
   localparam int PAT_SENSOR_ON = 1;
   localparam int PAT_PIPE_LSB = 2;

   // Balance word fields, gains are 2.6 fixed point
   localparam int BAL_RED_LSB = 0;
   localparam int BAL_BLUE_LSB = 8;
   localparam logic [7:0] BAL_UNITY = 8'h40;

   // Status word fields
   localparam int STAT_PHASE_LSB = 0;
   localparam int STAT_DRAIN = 2;
   localparam int STAT_FRAMES_LSB = 8;

   ////////////////////////////////////////////////////////////////////////////
   // Colour conversion, coefficients scaled by 256
   localparam logic [16:0] Y_R = 17'h0004D;
   localparam logic [16:0] Y_G = 17'h00096;
   localparam logic [16:0] Y_B = 17'h0001D;
   localparam logic [16:0] Y_ROUND = 17'h00080;
   localparam logic [16:0] CB_R = 17'h0002B;
   localparam logic [16:0] CB_G = 17'h00055;
   localparam logic [16:0] CR_G = 17'h0006B;
   localparam logic [16:0] CR_B = 17'h00015;
   localparam logic [16:0] C_HALF = 17'h00080;
   localparam logic [16:0] C_OFFSET = 17'h08000;

   // Full-scale masks of the 16-bit container per converter depth
   localparam logic [15:0] MASK_10 = 16'hFFC0;
   localparam logic [15:0] MASK_12 = 16'hFFF0;
   localparam logic [15:0] MASK_14 = 16'hFFFC;

   ////////////////////////////////////////////////////////////////////////////
   // Enumerations
   typedef enum logic [2:0] {
      chroma_full_8bit = 3'h0,
      chroma_half_8bit = 3'h1,
      chroma_quarter_8bit = 3'h2,
      mono_8bit = 3'h3,
      mosaic_16 = 3'h4
   } out_format_t;

   typedef enum logic [1:0] {
      adc_10 = 2'h0,
      adc_12 = 2'h1,
      adc_14 = 2'h2
   } adc_depth_t;

   typedef enum logic [1:0] {
      pat_off = 2'h0,
      pat_sensor = 2'h1,
      pat_increment = 2'h2,
      pat_frame_seq = 2'h3
   } pattern_choice_t;

   typedef enum logic [1:0] {
      mosaic_red_green_16 = 2'h0,
      mosaic_green_red_16 = 2'h1,
      mosaic_green_blue_16 = 2'h2,
      mosaic_blue_green_16 = 2'h3
   } mosaic_phase_t;

   typedef enum logic [1:0] {
      st_fill = 2'h1,
      st_drain = 2'h2
   } state_t;

   localparam logic [1:0] CTRL_ADC_RESET = 2'h1;

endpackage : fmt_pkg

// ===== verilog/ycc_if.sv
// Colour sample carrier between the formatter and its converter
`timescale 1ns/10ps
interface ycc_if;
   logic [7:0] r;
   logic [7:0] g;
   logic [7:0] b;
   logic [7:0] y;
   logic [7:0] cb;
   logic [7:0] cr;
   modport conv (input r, input g, input b, output y, output cb, output cr);
   modport src (output r, output g, output b, input y, input cb, input cr);
endinterface : ycc_if

// ===== verilog/rgb_to_ycc.sv
// Combinational RGB to YCbCr converter
`timescale 1ns/10ps
module rgb_to_ycc
   import fmt_pkg::*;
(
   // Colour samples
   ycc_if.conv pix
);

   logic [16:0] y_sum;
   logic [16:0] cb_sum;
   logic [16:0] cr_sum;

   // Offset sums never go negative, so plain unsigned arithmetic holds
   always_comb begin
      y_sum = Y_R * 17'(pix.r) + Y_G * 17'(pix.g) + Y_B * 17'(pix.b)
         + Y_ROUND;
      cb_sum = C_OFFSET + C_HALF * 17'(pix.b)
         - CB_R * 17'(pix.r) - CB_G * 17'(pix.g);
      cr_sum = C_OFFSET + C_HALF * 17'(pix.r)
         - CR_G * 17'(pix.g) - CR_B * 17'(pix.b);
   end

   // No rounding on chroma keeps both ends of 0..255 reachable
   assign pix.y = y_sum[15:8];
   assign pix.cb = cb_sum[15:8];
   assign pix.cr = cr_sum[15:8];

endmodule : rgb_to_ycc

// ===== verilog/image_output_formatter.sv
// Image output formatter: patterns, mirroring, alignment, chroma formats
//
// Summary of operation
// - Full-chroma format outputs luma and both chroma samples for every pixel.
// - Luma and chroma span 0 to 255 for RGB inputs in 0 to 255.
// - Half-chroma format keeps one chroma pair per two horizontal pixels.
// - Quarter-chroma format keeps one chroma pair per four horizontal pixels.
// - Narrower pixel formats drop the surplus low-order bits.
// - Wider pixel formats pad the extra low-order bits.
// - Samples sit most significant bit first in a 16-bit container.
// - A 12-bit sample leaves the four lowest container bits as padding.
// - Ten-bit samples reach 65472, fourteen-bit samples reach 65532.
// - Two generators; a selector picks which one a pattern write controls.
// - Pipeline-entry pattern enters after the sensor gain, ahead of balance, mirroring and conversion.
// - Increment pattern adds one per pixel and wraps from 255 to 0.
// - Frame sequence pattern varies per frame and restarts at acquisition.
// - Pipeline-entry pattern replaces the sensor pattern when both run.
// - Balance alters patterns; sensor gain never does.
// - Real sensor pixels pass only with both generators off.
// - Horizontal mirroring reverses each line.
// - Vertical mirroring reverses line order.
// - Mirroring updates the reported mosaic phase.
// - Luma is 0.299 red plus 0.587 green plus 0.114 blue.
// - Chroma is a weighted RGB sum offset by 128.
`timescale 1ns/10ps
module image_output_formatter
   import fmt_pkg::*;
#(
   parameter int FRAME_W = 16,
   parameter int FRAME_H = 8
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Converter pixel stream
   input wire logic in_valid,
   input wire logic in_sof,
   input wire logic [7:0] in_red,
   input wire logic [7:0] in_green,
   input wire logic [7:0] in_blue,
   input wire logic [13:0] in_raw,
   output logic in_ready,
   // Formatted pixel stream
   output logic out_valid,
   input wire logic out_ready,
   output logic [23:0] out_data,
   output logic out_chroma,
   output logic out_sof,
   output logic out_eol
);

   localparam int DEPTH = FRAME_W * FRAME_H;
   localparam int XW = $clog2(FRAME_W);
   localparam int YW = $clog2(FRAME_H);
   localparam int AW = $clog2(DEPTH);

   generate
      if (FRAME_W < 4 || FRAME_W % 4 != 0 || FRAME_H < 2) begin : g_chk
         $error("Frame width must be a multiple of 4, height at least 2");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Register state
   logic acq_en;
   logic acq_en_q;
   logic mirror_x;
   logic mirror_y;
   out_format_t out_fmt;
   adc_depth_t adc_depth;
   mosaic_phase_t base_phase;
   logic [1:0] gain_shift;
   logic pat_sel;
   logic sensor_on;
   pattern_choice_t pipe_mode;
   pattern_choice_t choice_in;
   logic [7:0] bal_red;
   logic [7:0] bal_blue;
   logic [7:0] frames_done;
   logic [1:0] rep_phase;
   state_t state;

   logic addr_ok;
   logic wr_pend;
   logic [7:0] wr_ofs;
   logic [31:0] rd_mux;

   assign hreadyout = 1'h1;
   assign hresp = 1'h0;
   assign addr_ok = hsel & hready & htrans[1];
   assign choice_in = pattern_choice_t'(hwdata[PAT_CHOICE_LSB +: 2]);
   assign rep_phase = base_phase ^ {mirror_y, mirror_x};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'h0;
         wr_ofs <= 8'h00;
      end else begin
         wr_pend <= addr_ok & hwrite & (hsize == 3'h2)
            & (haddr[31:8] == 24'h000000);
         wr_ofs <= haddr[7:0];
      end
   end

   always_comb begin
      rd_mux = 32'h00000000;
      if (haddr[31:8] == 24'h000000) begin
         unique case (haddr[7:0])
            CTRL_OFS: begin
               rd_mux[CTRL_ACQ] = acq_en;
               rd_mux[CTRL_MX] = mirror_x;
               rd_mux[CTRL_MY] = mirror_y;
               rd_mux[CTRL_FMT_LSB +: 3] = out_fmt;
               rd_mux[CTRL_ADC_LSB +: 2] = adc_depth;
               rd_mux[CTRL_PHASE_LSB +: 2] = base_phase;
               rd_mux[CTRL_GAIN_LSB +: 2] = gain_shift;
            end
            PAT_OFS: begin
               rd_mux[PAT_SEL] = pat_sel;
               rd_mux[PAT_SENSOR_ON] = sensor_on;
               rd_mux[PAT_PIPE_LSB +: 2] = pipe_mode;
            end
            BAL_OFS: begin
               rd_mux[BAL_RED_LSB +: 8] = bal_red;
               rd_mux[BAL_BLUE_LSB +: 8] = bal_blue;
            end
            STAT_OFS: begin
               rd_mux[STAT_PHASE_LSB +: 2] = rep_phase;
               rd_mux[STAT_DRAIN] = (state == st_drain);
               rd_mux[STAT_FRAMES_LSB +: 8] = frames_done;
            end
            default: rd_mux = 32'h00000000;
         endcase
      end
   end

   // Read data is caught at the address phase, so zero wait states
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (addr_ok && !hwrite) begin
         hrdata <= rd_mux;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acq_en <= 1'h0;
         mirror_x <= 1'h0;
         mirror_y <= 1'h0;
         out_fmt <= chroma_full_8bit;
         adc_depth <= adc_depth_t'(CTRL_ADC_RESET);
         base_phase <= mosaic_red_green_16;
         gain_shift <= 2'h0;
         bal_red <= BAL_UNITY;
         bal_blue <= BAL_UNITY;
      end else if (wr_pend && wr_ofs == CTRL_OFS) begin
         acq_en <= hwdata[CTRL_ACQ];
         mirror_x <= hwdata[CTRL_MX];
         mirror_y <= hwdata[CTRL_MY];
         out_fmt <= out_format_t'(hwdata[CTRL_FMT_LSB +: 3]);
         base_phase <= mosaic_phase_t'(hwdata[CTRL_PHASE_LSB +: 2]);
         gain_shift <= hwdata[CTRL_GAIN_LSB +: 2];
         // Depth changes mid-frame would mix alignments in one frame
         if (!acq_en) begin
            adc_depth <= adc_depth_t'(hwdata[CTRL_ADC_LSB +: 2]);
         end
      end else if (wr_pend && wr_ofs == BAL_OFS) begin
         bal_red <= hwdata[BAL_RED_LSB +: 8];
         bal_blue <= hwdata[BAL_BLUE_LSB +: 8];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pat_sel <= 1'h0;
         sensor_on <= 1'h0;
         pipe_mode <= pat_off;
      end else if (wr_pend && wr_ofs == PAT_OFS) begin
         pat_sel <= hwdata[PAT_SEL];
         if (!hwdata[PAT_SEL]) begin
            sensor_on <= (choice_in == pat_sensor);
         end else begin
            pipe_mode <= (choice_in == pat_sensor) ? pat_off : choice_in;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input stage
   function automatic logic [7:0] sat_shl(input logic [7:0] v,
                                          input logic [1:0] s);
      logic [10:0] w;
      w = {3'h0, v} << s;
      return (w > 11'h0FF) ? 8'hFF : w[7:0];
   endfunction : sat_shl

   function automatic logic [7:0] balance(input logic [7:0] v,
                                          input logic [7:0] k);
      logic [15:0] p;
      p = {8'h00, v} * {8'h00, k};
      return (p[15:14] != 2'h0) ? 8'hFF : p[13:6];
   endfunction : balance

   logic in_fire;
   logic [XW-1:0] col_cnt;
   logic [YW-1:0] row_cnt;
   logic [7:0] pix_cnt;
   logic [7:0] frame_seq;
   logic [XW-1:0] cur_x;
   logic [YW-1:0] cur_y;
   logic [7:0] pix8;
   logic [7:0] sens_pat;
   logic [7:0] pipe_pat;
   logic [15:0] depth_mask;
   logic [15:0] raw_al;
   logic [7:0] src_r;
   logic [7:0] src_g;
   logic [7:0] src_b;
   logic [15:0] src_raw;
   logic [XW-1:0] wr_col;
   logic [YW-1:0] wr_row;
   logic frame_last;
   logic acq_start;

   assign in_ready = acq_en && (state == st_fill);
   assign in_fire = in_valid & in_ready;
   assign cur_x = in_sof ? '0 : col_cnt;
   assign cur_y = in_sof ? '0 : row_cnt;
   assign pix8 = in_sof ? 8'h00 : pix_cnt;
   assign sens_pat = 8'(cur_x) ^ 8'(cur_y);
   assign pipe_pat = (pipe_mode == pat_frame_seq) ? pix8 + frame_seq : pix8;
   assign frame_last = in_fire && cur_x == XW'(FRAME_W - 1)
      && cur_y == YW'(FRAME_H - 1);
   assign acq_start = acq_en & ~acq_en_q;
   assign wr_col = mirror_x ? XW'(FRAME_W - 1) - cur_x : cur_x;
   assign wr_row = mirror_y ? YW'(FRAME_H - 1) - cur_y : cur_y;

   always_comb begin
      unique case (adc_depth)
         adc_10: begin
            raw_al = {in_raw[9:0], 6'h00};
            depth_mask = MASK_10;
         end
         adc_12: begin
            raw_al = {in_raw[11:0], 4'h0};
            depth_mask = MASK_12;
         end
         default: begin
            raw_al = {in_raw[13:0], 2'h0};
            depth_mask = MASK_14;
         end
      endcase
   end

   // Gain sits ahead of the sensor pattern, so it never reaches it
   always_comb begin
      src_r = sat_shl(in_red, gain_shift);
      src_g = sat_shl(in_green, gain_shift);
      src_b = sat_shl(in_blue, gain_shift);
      src_raw = raw_al;
      if (sensor_on) begin
         src_r = sens_pat;
         src_g = sens_pat;
         src_b = sens_pat;
         src_raw = {sens_pat, 8'h00} & depth_mask;
      end
      if (pipe_mode != pat_off) begin
         src_r = pipe_pat;
         src_g = pipe_pat;
         src_b = pipe_pat;
         src_raw = {pipe_pat, 8'h00} & depth_mask;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         col_cnt <= '0;
         row_cnt <= '0;
         pix_cnt <= 8'h00;
      end else if (frame_last) begin
         col_cnt <= '0;
         row_cnt <= '0;
         pix_cnt <= 8'h00;
      end else if (in_fire) begin
         col_cnt <= (cur_x == XW'(FRAME_W - 1)) ? '0 : cur_x + 1'h1;
         row_cnt <= (cur_x == XW'(FRAME_W - 1)) ? cur_y + 1'h1 : cur_y;
         pix_cnt <= pix8 + 8'h01;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acq_en_q <= 1'h0;
         frame_seq <= 8'h00;
      end else begin
         acq_en_q <= acq_en;
         if (acq_start) begin
            frame_seq <= 8'h00;
         end else if (frame_last) begin
            frame_seq <= frame_seq + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame store, written in mirrored order and read out in raster order
   logic [39:0] frame_mem [DEPTH];

   // Patterns are injected before balance and mirroring act on them
   always_ff @(posedge hclk) begin
      if (in_fire) begin
         frame_mem[AW'(wr_row) * AW'(FRAME_W) + AW'(wr_col)] <= {
            balance(src_r, bal_red), src_g, balance(src_b, bal_blue),
            src_raw};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Drain stage
   logic [AW:0] rd_idx;
   logic [XW-1:0] rd_col;
   logic [XW-1:0] out_col;
   logic rd_done;
   logic advance;
   logic [39:0] entry;
   logic keep;
   logic [23:0] next_data;
   ycc_if pix ();

   assign rd_done = (rd_idx == (AW + 1)'(DEPTH));
   assign advance = ~out_valid | out_ready;
   assign entry = frame_mem[rd_idx[AW-1:0]];
   assign pix.r = entry[39:32];
   assign pix.g = entry[31:24];
   assign pix.b = entry[23:16];

   rgb_to_ycc u_conv (
      .pix (pix)
   );

   always_comb begin
      unique case (out_fmt)
         chroma_full_8bit: keep = 1'h1;
         chroma_half_8bit: keep = (rd_col[0] == 1'h0);
         chroma_quarter_8bit: keep = (rd_col[1:0] == 2'h0);
         default: keep = 1'h0;
      endcase
      unique case (out_fmt)
         chroma_full_8bit, chroma_half_8bit, chroma_quarter_8bit:
            next_data = {pix.y, keep ? pix.cb : 8'h00, keep ? pix.cr : 8'h00};
         mono_8bit: next_data = {16'h0000, entry[15:8]};
         default: next_data = {8'h00, entry[15:0]};
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= st_fill;
         frames_done <= 8'h00;
      end else begin
         unique case (state)
            st_fill: if (frame_last) state <= st_drain;
            st_drain: begin
               if (advance && rd_done) begin
                  state <= st_fill;
                  frames_done <= frames_done + 8'h01;
               end
            end
            default: state <= st_fill;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_idx <= '0;
         rd_col <= '0;
         out_col <= '0;
         out_valid <= 1'h0;
         out_data <= 24'h000000;
         out_chroma <= 1'h0;
         out_sof <= 1'h0;
         out_eol <= 1'h0;
      end else if (state == st_drain && advance) begin
         if (rd_done) begin
            out_valid <= 1'h0;
            rd_idx <= '0;
            rd_col <= '0;
         end else begin
            out_valid <= 1'h1;
            out_data <= next_data;
            out_chroma <= keep;
            out_sof <= (rd_idx == '0);
            out_eol <= (rd_col == XW'(FRAME_W - 1));
            out_col <= rd_col;
            rd_idx <= rd_idx + 1'h1;
            rd_col <= (rd_col == XW'(FRAME_W - 1)) ? '0 : rd_col + 1'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking main_clk @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   full_chroma_a: assert property (
      out_valid && out_fmt == chroma_full_8bit |-> out_chroma)
      else $error("full chroma pixel without chroma");
   half_chroma_a: assert property (
      out_valid && out_fmt == chroma_half_8bit
      |-> out_chroma == (out_col[0] == 1'h0))
      else $error("half chroma pairing wrong");
   quarter_chroma_a: assert property (
      out_valid && out_fmt == chroma_quarter_8bit
      |-> out_chroma == (out_col[1:0] == 2'h0) && (out_chroma
      || out_data[15:0] == 16'h0000))
      else $error("quarter chroma pairing wrong");
   grey_chroma_a: assert property (
      pix.r == pix.g && pix.g == pix.b
      |-> pix.cb == 8'h80 && pix.cr == 8'h80 && pix.y == pix.r)
      else $error("grey input gives non neutral colour");
   full_range_a: assert property (
      pix.r == 8'h00 && pix.g == 8'h00 && pix.b == 8'hFF
      |-> pix.cb == 8'hFF && pix.cr < 8'h80)
      else $error("blue does not reach full chroma");
   pad_bits_a: assert property (
      out_valid && out_fmt == mosaic_16 && adc_depth == adc_12
      |-> out_data[3:0] == 4'h0 && out_data[23:16] == 8'h00)
      else $error("twelve bit padding not zero");
   incr_step_a: assert property (
      in_fire && pipe_mode == pat_increment && !in_sof
      && $past(in_fire) && $past(pipe_mode) == pat_increment
      |-> src_g == $past(src_g) + 8'h01)
      else $error("increment pattern did not step by one");
   incr_restart_a: assert property (
      in_fire && in_sof && pipe_mode == pat_increment |-> src_g == 8'h00)
      else $error("increment pattern did not restart");
   pipe_wins_a: assert property (
      in_fire && sensor_on && pipe_mode == pat_increment |-> src_g == pix8)
      else $error("sensor pattern not replaced");
   real_data_a: assert property (
      in_fire && !sensor_on && pipe_mode == pat_off && gain_shift == 2'h0
      |-> src_g == in_green && src_raw == raw_al)
      else $error("sensor data altered");
   mirror_x_a: assert property (
      in_fire && in_sof && mirror_x |-> wr_col == XW'(FRAME_W - 1))
      else $error("first pixel not stored at line end");
   mirror_y_a: assert property (
      in_fire && in_sof && mirror_y |-> wr_row == YW'(FRAME_H - 1))
      else $error("first line not stored at frame end");
   phase_flip_a: assert property (
      base_phase == mosaic_red_green_16 && mirror_x && !mirror_y
      |-> rep_phase == mosaic_green_red_16)
      else $error("mosaic phase not updated");
   seq_restart_a: assert property (
      acq_start |=> frame_seq == 8'h00)
      else $error("frame sequence did not restart");

   frame_drained_c: cover property (
      state == st_drain && advance && rd_done && mirror_x && mirror_y);
   half_stream_c: cover property (
      out_valid && out_ready && out_fmt == chroma_half_8bit && out_eol);
   pattern_frame_c: cover property (
      frame_last && pipe_mode == pat_increment && sensor_on);
   stall_c: cover property ((out_valid && !out_ready) [*3]);

endmodule : image_output_formatter

// ===== bench/pixel_sink.sv
// Host-side model that takes formatted pixels with random stalls
`timescale 1ns/10ps
module pixel_sink (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Pixel stream
   input wire logic out_valid,
   output logic out_ready
);
   // One cycle in four refused, so held outputs get tested
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) out_ready <= 1'b0;
      else out_ready <= !out_valid || ($urandom % 4) != 0;
   end
endmodule : pixel_sink

// ===== bench/testbench.sv
// Self-checking bench of the image output formatter
`timescale 1ns/10ps
module testbench
   import fmt_pkg::*;
;
   localparam int W = 8;
   localparam int N = 16;
   logic hclk, hresetn = 0, hsel = 0, hwrite = 0, hready;
   logic in_valid = 0, in_sof = 0, in_ready, out_valid, out_ready;
   logic out_chroma, out_sof, out_eol, hreadyout, hresp;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic [7:0] in_red = 0, in_green = 0, in_blue = 0;
   logic [13:0] in_raw = 0;
   logic [23:0] out_data;
   logic [24:0] e[N];
   logic [26:0] exp_q[$];
   int miscompares = 0;
   int n_tests = 0;

   image_output_formatter #(.FRAME_W(W), .FRAME_H(2)) dut (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .in_valid(in_valid), .in_sof(in_sof), .in_red(in_red),
      .in_green(in_green), .in_blue(in_blue), .in_raw(in_raw),
      .in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready),
      .out_data(out_data), .out_chroma(out_chroma), .out_sof(out_sof),
      .out_eol(out_eol));
   pixel_sink sink (.hclk(hclk), .hresetn(hresetn), .out_valid(out_valid),
      .out_ready(out_ready));

   always_comb hready = hreadyout;
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("Checks %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out

   task automatic check(string s, logic [31:0] x, logic [31:0] g);
      n_tests++;
      if (g !== x) begin
         $display("FAIL %s expected %h seen %h", s, x, g);
         miscompares++;
      end
   endtask : check

   task automatic give_up;
      miscompares++;
      close_out();
   endtask : give_up

   // Samples at the falling edge, clear of the rising-edge updates
   task automatic wait_hi(bit pix);
      int i = 0;
      do @(negedge hclk);
      while ((pix ? in_ready : hready) !== 1'b1 && ++i < 2000);
      if (i >= 2000) give_up();
      @(posedge hclk);
   endtask : wait_hi

   // Idle cycle at the end so a read never follows a write directly
   task automatic ahb(logic w, logic [7:0] a, logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      wait_hi(1'b0);
      htrans <= 2'h0;
      hwdata <= d;
      wait_hi(1'b0);
      rd = hrdata;
      check("hresp", 32'h0, 32'(hresp));
      @(posedge hclk);
   endtask : ahb

   task automatic rd_chk(logic [7:0] a, logic [31:0] x, logic [31:0] m);
      ahb(1'b0, a, 32'h0);
      check("register", x, rd & m);
   endtask : rd_chk

   // Acquisition stopped around every change of settings
   task automatic cfg(bit mx, int f, int d);
      for (int a = 0; a < 2; a++) begin
         ahb(1'b1, CTRL_OFS, a | mx << CTRL_MX | f << CTRL_FMT_LSB |
            d << CTRL_ADC_LSB);
      end
   endtask : cfg

   // Negative pat is sensor data, otherwise the grey offset of the pattern
   task automatic frame(int pat, int f, int bits, bit mx);
      int x;
      int i;
      logic [13:0] v;
      logic [15:0] c;
      logic [7:0] b;
      for (i = 0; i < N; i++) begin
         x = mx ? (i / W) * W + W - 1 - i % W : i;
         v = 14'($urandom) & 14'((1 << bits) - 1);
         c = 16'(v) << (16 - bits);
         b = i[0] ? 8'hFF : 8'($urandom);
         if (pat >= 0 && (f == 0 || i % (2 * f) == 0))
            e[x] = {1'b1, 8'(i + pat), 16'h8080};
         else if (pat >= 0) e[x] = {1'b0, 8'(i + pat), 16'h0};
         else if (f == 0) e[x] = {1'b1, 8'((Y_B * b + Y_ROUND) >> 8),
            8'((C_OFFSET + C_HALF * b) >> 8), 8'((C_OFFSET - CR_B * b) >> 8)};
         else if (f == 3) e[x] = {17'h0, c[15:8]};
         else e[x] = {9'h0, c};
         in_valid <= 1'b1;
         in_sof <= (i == 0);
         in_raw <= v;
         in_red <= f ? 8'($urandom) : 8'h00;
         in_green <= f ? 8'($urandom) : 8'h00;
         in_blue <= b;
         wait_hi(1'b1);
      end
      in_valid <= 1'b0;
      for (i = 0; i < N; i++) exp_q.push_back({i == 0, i % W == W - 1, e[i]});
      for (i = 0; i < 500 && exp_q.size() > 0; i++) @(posedge hclk);
      if (exp_q.size() > 0) give_up();
   endtask : frame

   always @(negedge hclk) begin
      if (hresetn && out_valid === 1'b1 && out_ready) begin
         check("pixel", exp_q.size() ? exp_q.pop_front() : '1,
            {out_sof, out_eol, out_chroma, out_data});
      end
   end

   initial begin
      void'($urandom(32'hB150D8F3));
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk(CTRL_OFS, 32'h40, '1);
      rd_chk(BAL_OFS, 32'h4040, '1);
      rd_chk(8'h40, 32'h0, '1);
      // Real sensor data at every converter depth
      for (int d = 0; d < 3; d++) begin
         cfg(1'b0, 4, d);
         frame(-1, 4, 10 + 2 * d, 1'b0);
      end
      // Surplus bits dropped in mono, then real colour conversion
      cfg(1'b0, 3, 2);
      frame(-1, 3, 14, 1'b0);
      cfg(1'b0, 0, 1);
      frame(-1, 0, 12, 1'b0);
      cfg(1'b1, 4, 1);
      rd_chk(STAT_OFS, 32'h1, 32'h3);
      frame(-1, 4, 12, 1'b1);
      // Both generators on, the pipeline one must win
      ahb(1'b1, PAT_OFS, 32'h2);
      ahb(1'b1, PAT_OFS, 32'h5);
      rd_chk(PAT_OFS, 32'hB, 32'hF);
      for (int f = 0; f < 3; f++) begin
         cfg(1'b0, f, 1);
         frame(0, f, 12, 1'b0);
      end
      // Frame sequence steps per frame and restarts on acquisition start
      ahb(1'b1, PAT_OFS, 32'h7);
      for (int k = 0; k < 3; k++) begin
         if (k != 1) cfg(1'b0, 0, 1);
         frame(k % 2, 0, 12, 1'b0);
      end
      close_out();
   end
endmodule : testbench
